// [include/oneshot_pwm_defs.vh]
// Purpose: Constants for the one-shot / PWM timer output block
// Assumes: Plain register port, 32-bit word addresses
// Notes:   Offsets and field positions chosen for this block
`ifndef ONESHOT_PWM_DEFS_VH
`define ONESHOT_PWM_DEFS_VH

// ==========================================================================
// Register offsets (byte addresses)
`define REG_CTL0        8'h00
`define REG_CTL1        8'h04
`define REG_PERIOD      8'h08
`define REG_WIDTH       8'h0c
`define REG_COUNT       8'h10
`define REG_EDGE_CFG    8'h14

// ==========================================================================
// Field positions
`define CTL0_CE_BIT     7
`define CTL1_EST_BIT    6
`define CTL1_MD_HI      2
`define CTL1_MD_LO      0

// ==========================================================================
// Mode codes and constants
`define MODE_ONESHOT    3'h3
`define MODE_PWM        3'h4
`define CNT_MAX         16'hffff
`define CNT_ZERO        16'h0000
`define CNT_ONE         16'h0001
`define EDGE_RISE       2'h1
`define EDGE_FALL       2'h2
`define EDGE_BOTH       2'h3

`endif

// [rtl/timer_unit.v]
// Purpose: One-shot pulse and PWM output modes of a 16-bit up counter
// Assumes: One clock; cnt_en_i is the count clock enable from a prescaler
// Notes:   Registers reached over a plain port, read data one cycle later
//
// Contract
// - Mode 011 selects one-shot pulse output
// - One-shot waits for trigger after enable
// - External edge or software bit triggers
// - Software trigger: aux output high while counting
// - Trigger moves counter FFFF to 0000, pulses
// - After pulse: counter 0000, stop, wait
// - Triggers during a running pulse are ignored, except on its final step
// - Delay compare-1, width compare-0 minus compare-1 plus 1
// - Period irq on clear after buffered match
// - Width irq when counter equals compare-1
// - No pulse when compare-1 exceeds compare-0
// - Missed period match wraps past FFFF
// - Missed width match gives no activation
// - One-shot period match: irq, inactive, halt
// - Mode 100 selects PWM output
// - PWM enable clears FFFF to 0000, runs
// - PWM width compare-1, period compare-0 plus 1
// - PWM aux output toggles each period
// - PWM compare writes load at counter clear
// - PWM period irq when counter clears
// - PWM buffers reload only after width register write
`timescale 1ns/1ns
`include "oneshot_pwm_defs.vh"

module timer_unit
#(
    parameter CW = 16
)
(
    input  wire          mclk_i,
    input  wire          rst_n_i,
    input  wire          cnt_en_i,
    input  wire          trigger_input_pin_i,
    input  wire [7:0]    addr_i,
    input  wire [31:0]   wdata_i,
    input  wire          wr_i,
    input  wire          rd_i,
    output reg  [31:0]   rdata_o,
    output reg           aux_timer_output_o,
    output reg           pulse_timer_output_o,
    output reg           period_match_irq_o,
    output reg           width_match_irq_o
);

// ==========================================================================
// Reset synchroniser
reg rst_s1;
reg rst_s2;
always @(posedge mclk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        rst_s1 <= 1'b0;
        rst_s2 <= 1'b0;
    end
    else
    begin
        rst_s1 <= 1'b1;
        rst_s2 <= rst_s1;
    end
end
wire rst_n = rst_s2;

// ==========================================================================
// Software registers and internal state
reg          count_enable_bit;
reg  [2:0]   timer_mode_sel;
reg  [1:0]   trigger_edge_config;
reg  [CW-1:0] period_compare_reg;
reg  [CW-1:0] width_compare_reg;
reg  [CW-1:0] period_compare_buffer;
reg  [CW-1:0] width_compare_buffer;
reg          reload_pending;
reg  [CW-1:0] counter;
reg          running;
reg          trig_prev;
reg          sw_trig_pend;
reg          ext_trig_pend;

wire wr_ctl0  = wr_i && (addr_i == `REG_CTL0);
wire wr_ctl1  = wr_i && (addr_i == `REG_CTL1);
wire wr_per   = wr_i && (addr_i == `REG_PERIOD);
wire wr_wid   = wr_i && (addr_i == `REG_WIDTH);
wire wr_edge  = wr_i && (addr_i == `REG_EDGE_CFG);

wire is_oneshot = (timer_mode_sel == `MODE_ONESHOT);
wire is_pwm     = (timer_mode_sel == `MODE_PWM);

// Software trigger bit reads back as zero: it only produces an event.
wire sw_trig = wr_ctl1 && wdata_i[`CTL1_EST_BIT];

// ==========================================================================
// External trigger edge detect
function edge_hit;
    input [1:0] cfg;
    input       prev;
    input       cur;
    begin
        case (cfg)
            `EDGE_RISE: edge_hit = !prev && cur;
            `EDGE_FALL: edge_hit = prev && !cur;
            `EDGE_BOTH: edge_hit = prev ^ cur;
            default:    edge_hit = 1'b0;
        endcase
    end
endfunction

wire ext_trig = edge_hit(trigger_edge_config, trig_prev, trigger_input_pin_i);

// Triggers arrive at clock rate; hold them until the next count clock.
wire trig_now = sw_trig_pend || ext_trig_pend;

// ==========================================================================
// Waveform timing
// The pins are registered, so they show a level one edge after the logic
// decides it. To make the pin switch exactly when the count shows the
// width value, the decision is taken on the step that lands on that value
// rather than on the step that leaves it. The interrupts keep the plain
// compare of the present count, as software expects them on the match.
//
// Limitation: compares are exact. A compare value that the count has
// already passed is not seen until the count comes round again, which is
// how the rewrite hazards of one-shot mode show up on the pins.

// True when the step now taken lands the count on the given value.
function reaches;
    input [CW-1:0] nxt;
    input [CW-1:0] target;
    begin
        reaches = (nxt == target);
    end
endfunction

// ==========================================================================
// Counter and waveform
wire step       = count_enable_bit && cnt_en_i;
wire [CW-1:0] count_inc = counter + `CNT_ONE;
wire per_match  = running && (counter == period_compare_buffer);
wire wid_match  = running && (counter == width_compare_buffer);
wire clear_now  = step && per_match;

reg [CW-1:0] next_counter;
reg          next_running;
reg          next_pulse;
reg          next_aux;
reg          next_pirq;
reg          next_wirq;

always @*
begin
    next_counter = counter;
    next_running = running;
    next_pulse   = pulse_timer_output_o;
    next_aux     = aux_timer_output_o;
    next_pirq    = 1'b0;
    next_wirq    = 1'b0;
    if (!count_enable_bit)
    begin
        next_counter = `CNT_MAX;
        next_running = 1'b0;
        next_pulse   = 1'b0;
        next_aux     = 1'b0;
    end
    else if (step)
    begin
        if (is_oneshot)
        begin
            if (!running)
            begin
                if (trig_now)
                begin
                    next_counter = `CNT_ZERO;
                    next_running = 1'b1;
                    // Only the trigger consumed now decides; the source of
                    // an earlier shot must not leak into this one.
                    next_aux     = sw_trig_pend;
                    // A zero delay makes the pulse start with the count.
                    next_pulse   = (width_compare_buffer == `CNT_ZERO);
                end
            end
            else if (per_match)
            begin
                // Trigger while pulse runs is dropped here.
                next_counter = `CNT_ZERO;
                next_running = 1'b0;
                next_pulse   = 1'b0;
                next_aux     = 1'b0;
                next_pirq    = 1'b1;
                next_wirq    = wid_match;
            end
            else
            begin
                // Wraps past FFFF when the period buffer was lowered.
                next_counter = count_inc;
                // Exact compare only: a skipped value never activates.
                if (reaches(count_inc, width_compare_buffer))
                    next_pulse = 1'b1;
                if (wid_match)
                    next_wirq  = 1'b1;
            end
        end
        else if (is_pwm)
        begin
            if (!running)
            begin
                next_counter = `CNT_ZERO;
                next_running = 1'b1;
                next_pulse   = (width_compare_buffer != `CNT_ZERO);
            end
            else if (per_match)
            begin
                next_counter = `CNT_ZERO;
                next_pirq    = 1'b1;
                next_aux     = !aux_timer_output_o;
                next_pulse   = (next_width(1'b0) != `CNT_ZERO);
                next_wirq    = wid_match;
            end
            else
            begin
                next_counter = count_inc;
                // Drop on the step that reaches the width, so the pin stays
                // high for exactly that many counts.
                if (reaches(count_inc, width_compare_buffer))
                    next_pulse = 1'b0;
                if (wid_match)
                    next_wirq  = 1'b1;
            end
        end
    end
end

// Width value in force after a clear, including a pending reload.
function [CW-1:0] next_width;
    input dummy;
    begin
        next_width = reload_pending ? width_compare_reg : width_compare_buffer;
    end
endfunction

// ==========================================================================
// Sequential state
always @(posedge mclk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        count_enable_bit      <= 1'b0;
        timer_mode_sel        <= 3'h0;
        trigger_edge_config   <= 2'h0;
        period_compare_reg    <= `CNT_MAX;
        width_compare_reg     <= `CNT_MAX;
        period_compare_buffer <= `CNT_MAX;
        width_compare_buffer  <= `CNT_MAX;
        reload_pending        <= 1'b0;
        counter               <= `CNT_MAX;
        running               <= 1'b0;
        // Idle level of the trigger pin, so reset gives no false edge.
        trig_prev             <= 1'b0;
        sw_trig_pend          <= 1'b0;
        ext_trig_pend         <= 1'b0;
        aux_timer_output_o    <= 1'b0;
        pulse_timer_output_o  <= 1'b0;
        period_match_irq_o    <= 1'b0;
        width_match_irq_o     <= 1'b0;
    end
    else
    begin
        trig_prev <= trigger_input_pin_i;
        if (wr_ctl0)
            count_enable_bit <= wdata_i[`CTL0_CE_BIT];
        if (wr_ctl1)
            timer_mode_sel <= wdata_i[`CTL1_MD_HI:`CTL1_MD_LO];
        if (wr_edge)
            trigger_edge_config <= wdata_i[1:0];
        if (wr_per)
            period_compare_reg <= wdata_i[CW-1:0];
        if (wr_wid)
            width_compare_reg <= wdata_i[CW-1:0];

        // Pending triggers: a new event wins over the consume.
        // A pending trigger is dropped by any step, so one that arrives
        // while a shot runs, before its final step, cannot restart the next idle phase.
        if (!count_enable_bit || !is_oneshot)
        begin
            sw_trig_pend  <= 1'b0;
            ext_trig_pend <= 1'b0;
        end
        else
        begin
            sw_trig_pend  <= sw_trig || (sw_trig_pend && !step);
            ext_trig_pend <= ext_trig || (ext_trig_pend && !step);
        end
        // In one-shot mode the buffers follow writes while the timer runs;
        // in PWM mode they wait for the clear after a width write.
        if (wr_wid)
            reload_pending <= 1'b1;
        else if (clear_now && is_pwm)
            reload_pending <= 1'b0;
        if ((clear_now && is_pwm && reload_pending) ||
            ((!running || !count_enable_bit) && reload_pending && !wr_wid))
        begin
            period_compare_buffer <= period_compare_reg;
            width_compare_buffer  <= width_compare_reg;
        end
        else if (is_oneshot && running)
        begin
            // Written values reach the compare at once; see rewrite hazards.
            period_compare_buffer <= period_compare_reg;
            width_compare_buffer  <= width_compare_reg;
        end
        if (!running && reload_pending && !wr_wid && !clear_now)
            reload_pending <= 1'b0;

        counter              <= next_counter;
        running              <= next_running;
        pulse_timer_output_o <= next_pulse;
        aux_timer_output_o   <= next_aux;
        period_match_irq_o   <= next_pirq;
        width_match_irq_o    <= next_wirq;
    end
end

// ==========================================================================
// Read path
// Read data stand for one cycle only and fall back to zero, so a stale
// value can never be mistaken for a fresh answer.
always @(posedge mclk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        rdata_o <= 32'h0000_0000;
    end
    else
    begin
        rdata_o <= 32'h0000_0000;
        if (rd_i)
        begin
            case (addr_i)
                `REG_CTL0:     rdata_o[`CTL0_CE_BIT] <= count_enable_bit;
                `REG_CTL1:     rdata_o[`CTL1_MD_HI:`CTL1_MD_LO] <= timer_mode_sel;
                `REG_PERIOD:   rdata_o[CW-1:0] <= period_compare_reg;
                `REG_WIDTH:    rdata_o[CW-1:0] <= width_compare_reg;
                `REG_COUNT:    rdata_o[CW-1:0] <= counter;
                `REG_EDGE_CFG: rdata_o[1:0] <= trigger_edge_config;
                default:       rdata_o <= 32'h0000_0000;
            endcase
        end
    end
end

endmodule

// [dv/trig_src.sv]
// Purpose: External trigger source model
// Assumes: Pin sampled on mclk_i, both edges valid
// Notes:   Pin holds its level between fires
`timescale 1ns/1ns
module trig_src
(
    input  wire  mclk_i,
    input  wire  fire_i,
    output logic pin_o
);
    initial pin_o = 1'b0;
    // Each fire gives one edge; the block is set to accept both
    always @(posedge mclk_i)
        if (fire_i)
            pin_o <= ~pin_o;
endmodule

// [dv/timer_unit_props.sv]
// Purpose: Port assertions for timer_unit
// Assumes: Control state shadowed from bus writes
// Notes:   Pulse and aux outputs move only on steps or writes
`timescale 1ns/1ns
`include "oneshot_pwm_defs.vh"
module timer_unit_chk
(
    input wire        mclk_i,
    input wire        rst_n_i,
    input wire        cnt_en_i,
    input wire        trigger_input_pin_i,
    input wire [7:0]  addr_i,
    input wire [31:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [31:0] rdata_o,
    input wire        aux_timer_output_o,
    input wire        pulse_timer_output_o,
    input wire        period_match_irq_o,
    input wire        width_match_irq_o
);
    logic       ce;
    logic [2:0] md;
    logic       os;
    always_ff @(posedge mclk_i or negedge rst_n_i)
        if (!rst_n_i)
        begin
            ce <= 1'b0;
            md <= 3'h0;
        end
        else if (wr_i && addr_i == `REG_CTL0)
            ce <= wdata_i[`CTL0_CE_BIT];
        else if (wr_i && addr_i == `REG_CTL1)
            md <= wdata_i[2:0];
    assign os = (md == `MODE_ONESHOT);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    irq0_step_a: assert property (period_match_irq_o |-> $past(cnt_en_i))
        else $error("period irq without a step");
    irq1_step_a: assert property (width_match_irq_o |-> $past(cnt_en_i))
        else $error("width irq without a step");
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside read slot");
    off_quiet_a: assert property (!ce && !$past(ce) && !$past(ce, 2)
        |-> !pulse_timer_output_o && !aux_timer_output_o)
        else $error("output active while disabled");
    out_steady_a: assert property ($changed({pulse_timer_output_o, aux_timer_output_o})
        |-> $past(cnt_en_i) || $past(wr_i) || $past(wr_i, 2))
        else $error("output moved without step");
    shot_end_a: assert property (ce && os && period_match_irq_o |-> !pulse_timer_output_o)
        else $error("pulse active at period match");
    shot_gap_a: assert property (os && period_match_irq_o |=> !period_match_irq_o [*2])
        else $error("one-shot did not halt");
    wirq_once_a: assert property (os && width_match_irq_o |=> !width_match_irq_o)
        else $error("width irq repeated");
    cover property (os && period_match_irq_o);
    cover property (md == `MODE_PWM && period_match_irq_o);
    cover property ($rose(pulse_timer_output_o));
endmodule
bind timer_unit timer_unit_chk u_chk (.*);

// [dv/tb_top.sv]
// Purpose: Self-checking bench for timer_unit
// Assumes: Random step enable from a fixed seed
// Notes:   Lengths counted in steps, not cycles
`timescale 1ns/1ns
`include "oneshot_pwm_defs.vh"
module tb_top;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        cnt_en_i = 1'b0;
    logic        go = 1'b0;
    logic        fire = 1'b0;
    logic        trig;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    wire  [31:0] rdata_o;
    wire         aux, pls, irq0, irq1;
    int          bad_count = 0;
    int          checks = 0;
    int          steps, hi, tot, dly, n0, n1, plen, phi, tgl, k, p, w;
    logic        last_aux = 1'b0;
    timer_unit DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cnt_en_i(cnt_en_i),
        .trigger_input_pin_i(trig), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .aux_timer_output_o(aux),
        .pulse_timer_output_o(pls), .period_match_irq_o(irq0), .width_match_irq_o(irq1));
    trig_src u_trig (.mclk_i(mclk_i), .fire_i(fire), .pin_o(trig));
    initial forever #2 mclk_i = ~mclk_i;
    // =========================================================
    // Step enable and waveform monitor
    always @(posedge mclk_i)
    begin
        cnt_en_i <= go ? ($urandom % 4 != 0) : 1'b0;
        if (irq0)
        begin
            plen = steps;
            phi = hi;
            steps = 0;
            hi = 0;
            n0++;
            tgl = (aux != last_aux);
            last_aux = aux;
        end
        if (cnt_en_i)
        begin
            steps++;
            hi += pls;
            tot += pls;
            dly += aux & ~pls;
        end
        n1 += irq1;
    end
    // =========================================================
    // Bus and checking tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        chk(rdata_o, exp, "read");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wait0(input int n);
        for (int i = 0; i < 3000 && n0 < n; i++)
            @(posedge mclk_i);
        if (n0 < n)
        begin
            bad_count++;
            $display("wrong value at %0t: no period irq", $time);
            end_of_test();
        end
    endtask
    task automatic trigger(input bit ext);
        if (ext)
        begin
            @(posedge mclk_i);
            fire <= 1'b1;
            @(posedge mclk_i);
            fire <= 1'b0;
        end
        else
            wr(`REG_CTL1, 32'h43);
    endtask
    task automatic shot(input int pv, input int wv, input bit ext);
        int b0, b1;
        wr(`REG_CTL0, 32'h0);
        wr(`REG_PERIOD, pv);
        wr(`REG_WIDTH, wv);
        wr(`REG_CTL1, {29'h0, `MODE_ONESHOT});
        wr(`REG_CTL0, 32'h80);
        repeat (4) @(posedge mclk_i);
        chk(pls, 1'b0, "idle pulse");
        b0 = n0;
        b1 = n1;
        tot = 0;
        dly = 0;
        trigger(ext);
        repeat (3) @(posedge mclk_i);
        trigger(ext);
        wait0(b0 + 1);
        repeat (30) @(posedge mclk_i);
        chk(n0 - b0, 1, "period irqs");
        chk(n1 - b1, wv > pv ? 0 : 1, "width irqs");
        chk(tot, wv > pv ? 0 : pv - wv + 1, "active width");
        chk(dly, ext ? 0 : (wv > pv ? pv + 1 : wv), "delay");
        chk(aux, 1'b0, "aux stopped");
        rd(`REG_COUNT, 32'h0);
        $display("one-shot %0d %0d %0d done", pv, wv, ext);
    endtask
    task automatic pwm(input int pv, input int wv, input int p2);
        wr(`REG_CTL0, 32'h0);
        wr(`REG_PERIOD, pv);
        wr(`REG_WIDTH, wv);
        wr(`REG_CTL1, {29'h0, `MODE_PWM});
        wr(`REG_CTL0, 32'h80);
        wait0(n0 + 3);
        chk(plen, pv + 1, "period");
        chk(phi, wv, "width");
        chk(tgl, 1, "aux toggle");
        wr(`REG_PERIOD, p2);
        wait0(n0 + 2);
        chk(plen, pv + 1, "unloaded period");
        wr(`REG_WIDTH, 1);
        wait0(n0 + 2);
        chk(plen, p2 + 1, "new period");
        chk(phi, 1, "new width");
        wr(`REG_CTL0, 32'h0);
        repeat (4) @(posedge mclk_i);
        chk({pls, aux}, 2'b00, "stopped");
        rd(`REG_COUNT, 32'hffff);
        $display("pwm %0d %0d done", pv, wv);
    endtask
    // =========================================================
    // Main sequence
    initial
    begin
        void'($urandom(42));
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        go <= 1'b1;
        rd(`REG_PERIOD, 32'hffff);
        rd(`REG_WIDTH, 32'hffff);
        rd(8'h1c, 32'h0);
        wr(`REG_EDGE_CFG, {30'h0, `EDGE_BOTH});
        shot(6, 0, 0);
        shot(6, 6, 1);
        shot(5, 9, 0);
        for (k = 0; k < 4; k++)
        begin
            p = 4 + $urandom % 30;
            w = $urandom % (p + 1);
            shot(p, w, k[0]);
            pwm(p, w, 3 + $urandom % 20);
        end
        pwm(7, 0, 4);
        pwm(7, 8, 9);
        end_of_test();
    end
endmodule
